/* sample_capture_controller.sv */
// Notes on behaviour
// - Internal mode takes one point per step interval of 1 to 100000 ms.
// - Capture length is 1 to 16384 points; reaching it ends one pass.
// - Shrinking length below points taken while running in single mode stops capture at once.
// - Shrinking length below points taken while running in loop mode restarts at position zero.
// - Four buffers of 16384 words of 32 bits.
// - Each buffer records one selectable quantity out of twenty-two.
// - A new quantity selection applies only from the next fresh start.
// - Internal mode times points itself and ignores the trigger input.
// - Pulse mode takes exactly one point per trigger pulse.
// - Single mode stops after one pass and waits for a new start.
// - Loop mode restarts after each pass and overwrites old points.
// - Start, pause and clear come only from the command register.
// - Start while paused resumes at the current position, keeping points.
// - Pause or clear while paused stops and discards stored points.
// - Start while stopped begins afresh at position zero.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "scc_regs.svh"

module sample_capture_controller #(
   parameter int TICK_CYCLES = `SCC_TICK_CYCLES
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   // Measurement quantities, source n at bits 32n+31..32n.
   input wire logic [`SCC_SOURCES*32-1:0] meas_bus,
   // Trigger pulse input.
   input wire logic external_sample_pulse_input,
   // Status.
   output logic capture_active,
   output logic capture_paused
);

   localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

   // ****************************************
   // State.
   // ****************************************
   typedef struct packed {
      scc_pkg::capture_state_e state;
      logic pulse_timed_trigger;
      logic loop_mode;
      logic [16:0] step_ms;
      logic [14:0] length;
      logic [19:0] sel;
      logic [19:0] active_sel;
      logic [14:0] pos;
      logic [14:0] fill;
      logic [16:0] tick_cnt;
      logic [16:0] step_cnt;
      logic [15:0] rd_ptr;
      logic [31:0] rdata;
      logic active;
      logic paused;
   } ctl_s;

   ctl_s q;
   ctl_s next_q;
   logic trig_rise;
   logic tick;
   logic cap;
   logic start_cmd;
   logic pause_cmd;
   logic len_wr;
   logic [14:0] len_new;
   logic [14:0] pos_inc;
   logic [31:0] buf_q [`SCC_BUFFERS];
   logic [31:0] buf_d [`SCC_BUFFERS];

   // ****************************************
   // Trigger input and buffers.
   // ****************************************

   // Synchronise the trigger and find its rising edge.
   pulse_edge_sync u_sync (
      .clk(ref_clk),
      .rstn(rstn),
      .din(external_sample_pulse_input),
      .rise(trig_rise)
   );

   // Each buffer stores its latched quantity at the current position.
   for (genvar i = 0; i < `SCC_BUFFERS; i++) begin : g_buf
      scc_pkg::source_sel_t s;
      assign s = q.active_sel[i*5 +: 5];
      assign buf_d[i] = (s < 5'(`SCC_SOURCES)) ? meas_bus[s*32 +: 32] : 32'h0;
      capture_buffer u_mem (
         .clk(ref_clk),
         .we(cap),
         .waddr(q.pos[13:0]),
         .wdata(buf_d[i]),
         .raddr(q.rd_ptr[13:0]),
         .rdata(buf_q[i])
      );
   end

   // ****************************************
   // Decode.
   // ****************************************

   // Commands and length writes from the register port.
   assign start_cmd = wr_en && addr == `SCC_ADDR_CMD && wdata[`SCC_CMD_START];
   assign pause_cmd = wr_en && addr == `SCC_ADDR_CMD && wdata[`SCC_CMD_PAUSE];
   assign len_wr = wr_en && addr == `SCC_ADDR_LEN;
   assign len_new = (wdata < 32'(`SCC_LEN_MIN)) ? `SCC_LEN_MIN :
                    (wdata > 32'(`SCC_LEN_MAX)) ? `SCC_LEN_MAX : wdata[14:0];
   assign pos_inc = q.pos + 15'h0001;
   assign tick = q.tick_cnt == TICK_LAST;

   // ****************************************
   // Next state.
   // ****************************************

   // Sequencer, timers and registers.
   always_comb begin
      next_q = q;
      cap = 1'b0;
      next_q.rdata = 32'h0;
      // Millisecond tick runs only while capturing.
      if (q.state == scc_pkg::ST_RUN) begin
         next_q.tick_cnt = tick ? 17'h0 : q.tick_cnt + 17'h1;
      end
      case (q.state)
         scc_pkg::ST_IDLE: begin
            if (start_cmd) begin
               next_q.state = scc_pkg::ST_RUN;
               next_q.pos = 15'h0;
               next_q.fill = 15'h0;
               next_q.active_sel = q.sel;
               next_q.tick_cnt = 17'h0;
               next_q.step_cnt = 17'h0;
            end else if (pause_cmd) begin
               next_q.pos = 15'h0;
               next_q.fill = 15'h0;
            end
         end
         scc_pkg::ST_RUN: begin
            if (pause_cmd) begin
               next_q.state = scc_pkg::ST_PAUSED;
            end else begin
               if (q.pulse_timed_trigger) begin
                  cap = trig_rise;
               end else if (tick) begin
                  // Internal timing ignores the trigger input.
                  if (q.step_cnt + 17'h1 >= q.step_ms) begin
                     cap = 1'b1;
                     next_q.step_cnt = 17'h0;
                  end else begin
                     next_q.step_cnt = q.step_cnt + 17'h1;
                  end
               end
               if (cap) begin
                  next_q.fill = (pos_inc > q.fill) ? pos_inc : q.fill;
                  if (pos_inc >= q.length) begin
                     next_q.pos = 15'h0;
                     if (!q.loop_mode) begin
                        next_q.state = scc_pkg::ST_IDLE;
                     end
                  end else begin
                     next_q.pos = pos_inc;
                  end
               end
            end
         end
         scc_pkg::ST_PAUSED: begin
            if (start_cmd) begin
               next_q.state = scc_pkg::ST_RUN;
               next_q.tick_cnt = 17'h0;
            end else if (pause_cmd) begin
               next_q.state = scc_pkg::ST_IDLE;
               next_q.pos = 15'h0;
               next_q.fill = 15'h0;
            end
         end
         default: begin
            next_q.state = scc_pkg::ST_IDLE;
         end
      endcase
      // Register writes.
      if (wr_en) begin
         case (addr)
            `SCC_ADDR_CTRL: begin
               next_q.pulse_timed_trigger = wdata[`SCC_CTRL_PULSE];
               next_q.loop_mode = wdata[`SCC_CTRL_LOOP];
            end
            `SCC_ADDR_STEP: begin
               if (wdata < 32'(`SCC_STEP_MIN)) begin
                  next_q.step_ms = `SCC_STEP_MIN;
               end else if (wdata > 32'(`SCC_STEP_MAX)) begin
                  next_q.step_ms = `SCC_STEP_MAX;
               end else begin
                  next_q.step_ms = wdata[16:0];
               end
            end
            `SCC_ADDR_LEN: begin
               next_q.length = len_new;
            end
            `SCC_ADDR_SEL: begin
               next_q.sel = wdata[19:0];
            end
            `SCC_ADDR_RDPTR: begin
               next_q.rd_ptr = wdata[15:0];
            end
            default: begin
            end
         endcase
      end
      // A shorter length than the points taken while running ends or restarts the pass.
      if (len_wr && q.state == scc_pkg::ST_RUN && len_new < q.pos) begin
         next_q.pos = 15'h0;
         if (!q.loop_mode) begin
            next_q.state = scc_pkg::ST_IDLE;
         end else begin
            next_q.state = scc_pkg::ST_RUN;
         end
      end
      // Register reads; data stand in the next cycle only.
      if (rd_en) begin
         case (addr)
            `SCC_ADDR_CTRL: next_q.rdata = {30'h0, q.loop_mode, q.pulse_timed_trigger};
            `SCC_ADDR_STEP: next_q.rdata = {15'h0, q.step_ms};
            `SCC_ADDR_LEN: next_q.rdata = {17'h0, q.length};
            `SCC_ADDR_SEL: next_q.rdata = {12'h0, q.sel};
            `SCC_ADDR_STATUS: next_q.rdata = {1'b0, q.pos, 14'h0, q.state};
            `SCC_ADDR_RDPTR: next_q.rdata = {16'h0, q.rd_ptr};
            `SCC_ADDR_RDDATA: begin
               // Discarded positions read as zero.
               if ({1'b0, q.rd_ptr[13:0]} < q.fill) begin
                  next_q.rdata = buf_q[q.rd_ptr[15:14]];
               end
            end
            `SCC_ADDR_FILL: next_q.rdata = {17'h0, q.fill};
            default: next_q.rdata = 32'h0;
         endcase
      end
      next_q.active = next_q.state == scc_pkg::ST_RUN;
      next_q.paused = next_q.state == scc_pkg::ST_PAUSED;
   end

   // State register.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '{state: scc_pkg::ST_IDLE, step_ms: `SCC_STEP_RST,
                length: `SCC_LEN_RST, default: '0};
      end else begin
         q <= next_q;
      end
   end

   assign rdata = q.rdata;
   assign capture_active = q.active;
   assign capture_paused = q.paused;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   AST_RESUME_KEEPS: assert property (
      q.state == scc_pkg::ST_PAUSED && start_cmd |=>
      q.state == scc_pkg::ST_RUN && q.pos == $past(q.pos) && q.fill == $past(q.fill))
      else $error("resume lost position or points");
   AST_SECOND_PAUSE: assert property (
      q.state == scc_pkg::ST_PAUSED && pause_cmd && !start_cmd |=>
      q.state == scc_pkg::ST_IDLE && q.fill == 15'h0 && q.pos == 15'h0)
      else $error("second pause did not discard");
   AST_FRESH_START: assert property (
      q.state == scc_pkg::ST_IDLE && start_cmd |=>
      q.state == scc_pkg::ST_RUN && q.pos == 15'h0 && q.fill == 15'h0)
      else $error("fresh start not at position zero");
   AST_SINGLE_END: assert property (
      cap && !q.loop_mode && pos_inc >= q.length && !len_wr |=>
      q.state == scc_pkg::ST_IDLE && !capture_active)
      else $error("single pass did not stop");
   AST_LOOP_WRAP: assert property (
      cap && q.loop_mode && pos_inc >= q.length |=> q.state == scc_pkg::ST_RUN && q.pos == 15'h0)
      else $error("loop pass did not wrap");
   AST_SHRINK_SINGLE: assert property (
      len_wr && q.state == scc_pkg::ST_RUN && !q.loop_mode && len_new < q.pos |=>
      q.state == scc_pkg::ST_IDLE && !capture_active)
      else $error("shrink in single mode did not stop");
   AST_SHRINK_LOOP: assert property (
      len_wr && q.state == scc_pkg::ST_RUN && q.loop_mode && len_new < q.pos |=>
      q.state == scc_pkg::ST_RUN && q.pos == 15'h0)
      else $error("shrink in loop mode did not restart");
   AST_SEL_HELD: assert property (
      q.state != scc_pkg::ST_IDLE |=> $stable(q.active_sel))
      else $error("selection changed during capture");
   AST_PULSE_POINT: assert property (
      cap && q.pulse_timed_trigger |-> trig_rise && $past(trig_rise) == 1'b0)
      else $error("pulse point without a fresh edge");
   AST_INT_TIMING: assert property (
      cap && !q.pulse_timed_trigger |-> tick ##1 q.step_cnt == 17'h0)
      else $error("internal point off the tick or no reload");

   COV_SINGLE_PASS: cover property (cap && !q.loop_mode && pos_inc >= q.length);
   COV_LOOP_WRAP: cover property (cap && q.loop_mode && pos_inc >= q.length);
   COV_PAUSE_RESUME: cover property (q.state == scc_pkg::ST_PAUSED && start_cmd);
   COV_PULSE_POINT: cover property (cap && q.pulse_timed_trigger);

endmodule // sample_capture_controller

/* scc_regs.svh */
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// ****************************************
// Register byte addresses.
// ****************************************
`define SCC_ADDR_CTRL 8'h00
`define SCC_ADDR_STEP 8'h04
`define SCC_ADDR_LEN 8'h08
`define SCC_ADDR_SEL 8'h0c
`define SCC_ADDR_CMD 8'h10
`define SCC_ADDR_STATUS 8'h14
`define SCC_ADDR_RDPTR 8'h18
`define SCC_ADDR_RDDATA 8'h1c
`define SCC_ADDR_FILL 8'h20

// ****************************************
// Field positions.
// ****************************************
`define SCC_CTRL_PULSE 0
`define SCC_CTRL_LOOP 1
`define SCC_CMD_START 0
`define SCC_CMD_PAUSE 1

// ****************************************
// Reset values and limits.
// ****************************************
`define SCC_STEP_RST 17'h00001
`define SCC_STEP_MIN 17'h00001
`define SCC_STEP_MAX 17'h186a0
`define SCC_LEN_RST 15'h4000
`define SCC_LEN_MIN 15'h0001
`define SCC_LEN_MAX 15'h4000
`define SCC_SOURCES 22
`define SCC_BUFFERS 4
`define SCC_DEPTH 16384

// ****************************************
// Timing.
// ****************************************
`define SCC_CLK_NS 10
`define SCC_MS_NS 1000000
`define SCC_TICK_CYCLES (`SCC_MS_NS / `SCC_CLK_NS)

`endif

/* scc_pkg.sv */
package scc_pkg;

   // Capture sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_PAUSED = 2'b10
   } capture_state_e;

   // Quantity selector of one buffer.
   typedef logic [4:0] source_sel_t;

   // Word position inside one buffer.
   typedef logic [13:0] buf_addr_t;

endpackage

/* capture_buffer.sv */
`timescale 1ns/1ps

module capture_buffer (
   // Clock.
   input wire logic clk,
   // Write side.
   input wire logic we,
   input wire scc_pkg::buf_addr_t waddr,
   input wire logic [31:0] wdata,
   // Read side.
   input wire scc_pkg::buf_addr_t raddr,
   output logic [31:0] rdata
);

   // Storage of one capture buffer.
   logic [31:0] mem [0:16383];

   // One write port, one registered read port.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // capture_buffer

/* pulse_edge_sync.sv */
`timescale 1ns/1ps

module pulse_edge_sync (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Raw input and its rising edge.
   input wire logic din,
   output logic rise
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_s;

   sync_s q;
   sync_s next_q;

   // Shift the input through two stages, then one for the edge.
   always_comb begin
      next_q.s1 = din;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Only the second and third stages are compared.
   assign rise = q.s2 & ~q.s3;

endmodule // pulse_edge_sync

/* trig_pulse_source.sv */
`timescale 1ns/1ps

module trig_pulse_source #(
   parameter int HIGH_CYCLES = 3,
   parameter int GAP_CYCLES = 6
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Burst request from the bench.
   input wire logic go,
   input wire logic [7:0] count,
   // Trigger line and burst status.
   output logic pulse,
   output logic busy
);
   // ****************************************
   // Pulse burst generator.
   // ****************************************
   // The line idles low, and every pulse is followed by a low gap so the rate stays bounded.
   // A request sends count pulses, each high for HIGH_CYCLES and then low for GAP_CYCLES.
   always begin
      @(posedge ref_clk);
      if (!rstn) begin
         pulse <= 1'b0;
         busy <= 1'b0;
      end else if (go) begin
         busy <= 1'b1;
         for (int i = 0; i < count; i++) begin
            pulse <= 1'b1;
            repeat (HIGH_CYCLES) @(posedge ref_clk);
            pulse <= 1'b0;
            repeat (GAP_CYCLES) @(posedge ref_clk);
         end
         busy <= 1'b0;
      end
   end
endmodule // trig_pulse_source

/* sample_capture_controller_tb.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end

module sample_capture_controller_tb;
   logic ref_clk, rstn, wr_en, rd_en, go, trig, capture_active, capture_paused, busy;
   logic [7:0] addr, n_pulse;
   logic [31:0] wdata, rdata, v;
   logic [`SCC_SOURCES*32-1:0] meas_bus;
   int n_fail = 0;
   int tests_run = 0;
   int srcs[4] = '{3, 21, 17, 12};

   sample_capture_controller #(.TICK_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .meas_bus(meas_bus),
      .external_sample_pulse_input(trig), .capture_active(capture_active), .capture_paused(capture_paused));

   // One pulse every 20 cycles, two of the scaled 10-cycle milliseconds, keeps the 500 Hz bound.
   trig_pulse_source #(.HIGH_CYCLES(3), .GAP_CYCLES(17)) i_src (.ref_clk(ref_clk), .rstn(rstn),
      .go(go), .count(n_pulse), .pulse(trig), .busy(busy));

   // ****************************************
   // Clock, access tasks and verdict.
   // ****************************************
   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] src_val(input int n);
      return 32'h5a000000 + n;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rdbuf(input logic [1:0] b, input logic [13:0] w, output logic [31:0] d);
      wr(`SCC_ADDR_RDPTR, {16'h0000, b, w});
      repeat (2) @(posedge ref_clk);
      rd(`SCC_ADDR_RDDATA, d);
   endtask

   task automatic fire(input logic [7:0] n);
      @(posedge ref_clk);
      n_pulse <= n;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      #1;
      repeat (300) if (busy === 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic wait_idle();
      repeat (400) if (capture_active !== 1'b0) @(posedge ref_clk);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Cuts a hang short; the tests need well under 5000 cycles.
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      tally_and_finish();
   end

   // ****************************************
   // Test sequence.
   // ****************************************
   // Each source carries a distinct constant so stored words show which quantity was taken.
   initial begin
      rstn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      go = 1'b0;
      addr = 8'h00;
      wdata = 32'h00000000;
      n_pulse = 8'h00;
      for (int n = 0; n < `SCC_SOURCES; n++) meas_bus[32*n +: 32] = src_val(n);
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(`SCC_ADDR_LEN, v);
      `CHK("len", 32'h00004000, v)
      @(posedge ref_clk);
      #1 `CHK("rd_idle", 32'h00000000, rdata)
      wr(`SCC_ADDR_LEN, 32'h00008000);
      rd(`SCC_ADDR_LEN, v);
      `CHK("len_max", 32'h00004000, v)
      rd(`SCC_ADDR_STEP, v);
      `CHK("step", 32'h00000001, v)
      rd(`SCC_ADDR_CTRL, v);
      `CHK("ctrl", 32'h00000000, v)
      rd(8'hfc, v);
      `CHK("unmapped", 32'h00000000, v)
      wr(`SCC_ADDR_STEP, 32'h00000000);
      rd(`SCC_ADDR_STEP, v);
      `CHK("step_min", 32'h00000001, v)
      wr(`SCC_ADDR_STEP, 32'h000186a1);
      rd(`SCC_ADDR_STEP, v);
      `CHK("step_max", 32'h000186a0, v)
      $display("test reset done");
      // Internal timing, four ticks per point; trigger pulses and a new selection must not matter.
      wr(`SCC_ADDR_SEL, {12'h000, 5'h0c, 5'h11, 5'h15, 5'h03});
      wr(`SCC_ADDR_STEP, 32'h00000004);
      wr(`SCC_ADDR_LEN, 32'h00000003);
      wr(`SCC_ADDR_CMD, 32'h00000001);
      wr(`SCC_ADDR_SEL, 32'h00000000);
      fire(8'h02);
      repeat (10) @(posedge ref_clk);
      rd(`SCC_ADDR_FILL, v);
      `CHK("fill_mid", 32'h00000001, v)
      wait_idle();
      rd(`SCC_ADDR_FILL, v);
      `CHK("fill_end", 32'h00000003, v)
      for (int b = 0; b < 4; b++) begin
         for (int w = 0; w < 4; w++) begin
            rdbuf(2'(b), 14'(w), v);
            `CHK("buf", (w < 3) ? src_val(srcs[b]) : 32'h00000000, v)
         end
      end
      $display("test internal done");
      // Pulse mode with pause and resume.
      wr(`SCC_ADDR_CTRL, 32'h00000001);
      wr(`SCC_ADDR_LEN, 32'h00000004);
      wr(`SCC_ADDR_CMD, 32'h00000001);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("fresh", 32'h00000001, v)
      fire(8'h03);
      rd(`SCC_ADDR_FILL, v);
      `CHK("fill_pulse", 32'h00000003, v)
      wr(`SCC_ADDR_CMD, 32'h00000002);
      fire(8'h01);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("paused", 32'h00030002, v)
      `CHK("paused_pin", 1'b1, capture_paused)
      wr(`SCC_ADDR_CMD, 32'h00000001);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("resume", 32'h00030001, v)
      fire(8'h01);
      wait_idle();
      rd(`SCC_ADDR_FILL, v);
      `CHK("fill_single", 32'h00000004, v)
      rdbuf(2'h1, 14'h0000, v);
      `CHK("new_sel", src_val(0), v)
      $display("test pulse done");
      // Shrinking the length in single mode.
      wr(`SCC_ADDR_LEN, 32'h0000000a);
      wr(`SCC_ADDR_CMD, 32'h00000001);
      fire(8'h03);
      wr(`SCC_ADDR_LEN, 32'h00000002);
      repeat (3) @(posedge ref_clk);
      #1 `CHK("shrink_stop", 1'b0, capture_active)
      wr(`SCC_ADDR_CMD, 32'h00000002);
      rd(`SCC_ADDR_FILL, v);
      `CHK("idle_clear", 32'h00000000, v)
      $display("test shrink done");
      // Loop mode: shrink restart, wrap, then double pause clears.
      wr(`SCC_ADDR_CTRL, 32'h00000003);
      wr(`SCC_ADDR_LEN, 32'h00000004);
      wr(`SCC_ADDR_CMD, 32'h00000001);
      fire(8'h03);
      wr(`SCC_ADDR_LEN, 32'h00000002);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("loop_restart", 32'h00000001, v)
      fire(8'h03);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("loop_wrap", 32'h00010001, v)
      wr(`SCC_ADDR_CMD, 32'h00000002);
      wr(`SCC_ADDR_CMD, 32'h00000002);
      rd(`SCC_ADDR_STATUS, v);
      `CHK("cleared", 32'h00000000, v)
      rd(`SCC_ADDR_FILL, v);
      `CHK("fill_clear", 32'h00000000, v)
      $display("test loop done");
      tally_and_finish();
   end
endmodule // sample_capture_controller_tb
